/* File: inc/qmu_pkg.sv */
`default_nettype none
package qmu_pkg;
  // register byte offsets
  localparam logic [10:0] RXCTL2_ADDR    = 11'h176;
  localparam logic [10:0] TXFREE_ADDR    = 11'h178;
  localparam logic [10:0] RSVD_ADDR      = 11'h17a;
  // receive_control_two fields
  localparam int          PAUSE_EN_BIT   = 8;
  localparam int          FRAG_PASS_BIT  = 4;
  localparam int          RSVD3_BIT      = 3;
  localparam int          LITE_EN_BIT    = 2;
  localparam int          ICMP_CHK_BIT   = 1;
  localparam int          SA_FILT_BIT    = 0;
  localparam logic [15:0] RXCTL2_RESET   = 16'hff14;
  localparam logic [15:0] RXCTL2_WMASK   = 16'h011f;
  // transmit_queue_free_space
  localparam int          TXFREE_W       = 13;
  localparam logic [12:0] TXFREE_RESET   = 13'h1800;
  // pause timer
  localparam int          CLK_PERIOD_NS  = 5;
  localparam int          PAUSE_TIME_US  = 20;
  localparam int          PAUSE_CYC_INT  = (PAUSE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam logic [11:0] PAUSE_CYCLES   = 12'(PAUSE_CYC_INT);

  typedef enum logic {PT_IDLE, PT_RUN} qmu_pt_state_type;

  typedef struct packed {
    qmu_pt_state_type st;
    logic [11:0]      cnt;
    logic             send;
  } qmu_pt_type;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [12:0] free;
    logic [15:0] rdata;
    logic        drop;
    logic        accept;
  } qmu_main_type;
endpackage
`default_nettype wire

/* File: logic/qmu_pause_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module qmu_pause_timer (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // control and queue levels
  input  wire logic enable,
  input  wire logic over_low,
  input  wire logic over_pause,
  // pause request
  output logic      pause_send,
  output logic      running
);
  qmu_pkg::qmu_pt_type s_r;
  qmu_pkg::qmu_pt_type s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.send = 1'b0;
    unique case (s_r.st)
      qmu_pkg::PT_IDLE: begin
        // first pause goes out at the pause threshold, below the high mark
        if (enable && over_pause) begin
          s_nxt.send = 1'b1;
          s_nxt.st   = qmu_pkg::PT_RUN;
          s_nxt.cnt  = 12'h000;
        end
      end
      qmu_pkg::PT_RUN: begin
        if (!enable || !over_low) begin
          s_nxt.st  = qmu_pkg::PT_IDLE;
          s_nxt.cnt = 12'h000;
        end else if (s_r.cnt == qmu_pkg::PAUSE_CYCLES - 12'h001) begin
          s_nxt.send = 1'b1;
          s_nxt.cnt  = 12'h000;
        end else begin
          s_nxt.cnt = s_r.cnt + 12'h001;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '{st: qmu_pkg::PT_IDLE, cnt: 12'h000, send: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pause_send = s_r.send;
  assign running    = (s_r.st == qmu_pkg::PT_RUN);

  a_first_pause: assert property (@(posedge clk) disable iff (!resetn)
    (!running && enable && over_pause) |=> (pause_send && running))
    else $error("first pause frame not sent");
  a_timer_stop: assert property (@(posedge clk) disable iff (!resetn)
    (running && !over_low) |=> (!running && !pause_send))
    else $error("pause timer kept running below low mark");
  a_resend_expiry: assert property (@(posedge clk) disable iff (!resetn)
    (running && enable && over_low && s_r.cnt == qmu_pkg::PAUSE_CYCLES - 12'h001)
      |=> (pause_send && running && s_r.cnt == 12'h000))
    else $error("no pause frame on timer expiry");
  a_restart_gap: assert property (@(posedge clk) disable iff (!resetn)
    (pause_send && running) ##1 (enable && over_low && running) [*8] |-> !pause_send)
    else $error("pause frame sent before timer expiry");
endmodule
`default_nettype wire

/* File: logic/qmu_rx_control_tx_mem_info.sv */
// What this block does
// - With the pause timer enabled, an expiry while the receive queue is above its low mark sends another pause.
// - The pause timer restarts itself on expiry while the receive queue stays above the low mark.
// - The pause timer stops once the receive queue drops below the low mark.
// - The first pause frame goes out before the receive queue passes the high mark.
// - With fragment pass set, its default, fragmented IPv6 UDP frames skip the UDP checksum check.
// - With UDP-Lite enabled, UDP-Lite checksums are checked on receive and generated on transmit.
// - With UDP-Lite disabled, UDP-Lite checksums are neither checked on receive nor generated on transmit.
// - With the ICMP check set, a non-fragmented ICMP frame with a bad checksum is dropped.
// - With the ICMP check cleared, ICMP frames with bad checksums are still delivered.
// - With source filtering set, a frame whose source address equals the station address is dropped.
// - The free-space field in bits 12 to 0 counts free transmit queue bytes and reads 0x1800 after reset.
// - Frame payload and control words share the transmit queue and both count against free space.
`timescale 1ns/100ps
`default_nettype none
module qmu_rx_control_tx_mem_info (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register port
  input  wire logic        reg_cs,
  input  wire logic        reg_we,
  input  wire logic [10:0] reg_addr,
  input  wire logic [1:0]  reg_be,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // receive queue levels
  input  wire logic        receive_queue_over_low,
  input  wire logic        receive_queue_over_pause,
  output logic             pause_frame_req,
  // receive frame checks
  input  wire logic        rx_frame_done,
  input  wire logic        rx_ipv6_udp_frag,
  input  wire logic        rx_udp_csum_bad,
  input  wire logic        rx_udp_lite,
  input  wire logic        rx_udp_lite_csum_bad,
  input  wire logic        rx_icmp,
  input  wire logic        rx_ip_fragment,
  input  wire logic        rx_icmp_csum_bad,
  input  wire logic [47:0] rx_src_addr,
  input  wire logic [47:0] station_addr,
  output logic             rx_drop,
  output logic             rx_accept,
  // transmit side
  output logic             tx_udp_lite_csum_gen,
  input  wire logic        transmit_queue_write,
  input  wire logic [12:0] transmit_queue_write_bytes,
  input  wire logic        transmit_queue_release,
  input  wire logic [12:0] transmit_queue_release_bytes
);
  qmu_pkg::qmu_main_type s_r;
  qmu_pkg::qmu_main_type s_nxt;

  logic        pause_en;
  logic        frag_pass;
  logic        lite_en;
  logic        icmp_en;
  logic        sa_en;
  logic        sa_hit;
  logic        icmp_hit;
  logic        lite_hit;
  logic        frag_hit;
  logic [14:0] free_sum;
  logic [14:0] free_dec;

  assign pause_en  = s_r.ctrl[qmu_pkg::PAUSE_EN_BIT];
  assign frag_pass = s_r.ctrl[qmu_pkg::FRAG_PASS_BIT];
  assign lite_en   = s_r.ctrl[qmu_pkg::LITE_EN_BIT];
  assign icmp_en   = s_r.ctrl[qmu_pkg::ICMP_CHK_BIT];
  assign sa_en     = s_r.ctrl[qmu_pkg::SA_FILT_BIT];

  // drop causes
  assign sa_hit   = sa_en && (rx_src_addr == station_addr);
  assign icmp_hit = icmp_en && rx_icmp && !rx_ip_fragment && rx_icmp_csum_bad;
  assign lite_hit = lite_en && rx_udp_lite && rx_udp_lite_csum_bad;
  // fragment pass skips the udp check; cleared mode is unsupported and just checks
  assign frag_hit = !frag_pass && rx_ipv6_udp_frag && rx_udp_csum_bad;

  // payload and control words share one count
  assign free_sum = {2'b00, s_r.free}
                  + (transmit_queue_release ? {2'b00, transmit_queue_release_bytes} : 15'h0000);
  assign free_dec = transmit_queue_write ? {2'b00, transmit_queue_write_bytes} : 15'h0000;

  always_comb begin
    s_nxt        = s_r;
    s_nxt.drop   = 1'b0;
    s_nxt.accept = 1'b0;
    if (reg_cs && reg_we && reg_addr == qmu_pkg::RXCTL2_ADDR) begin
      if (reg_be[0]) begin
        s_nxt.ctrl[7:0] = (s_r.ctrl[7:0] & ~qmu_pkg::RXCTL2_WMASK[7:0])
                        | (reg_wdata[7:0] & qmu_pkg::RXCTL2_WMASK[7:0]);
      end
      if (reg_be[1]) begin
        s_nxt.ctrl[15:8] = (s_r.ctrl[15:8] & ~qmu_pkg::RXCTL2_WMASK[15:8])
                         | (reg_wdata[15:8] & qmu_pkg::RXCTL2_WMASK[15:8]);
      end
    end
    if (reg_cs && !reg_we) begin
      unique case (reg_addr)
        qmu_pkg::RXCTL2_ADDR: s_nxt.rdata = s_r.ctrl;
        qmu_pkg::TXFREE_ADDR: s_nxt.rdata = {3'h0, s_r.free};
        default:              s_nxt.rdata = 16'h0000;
      endcase
    end
    if (rx_frame_done) begin
      if (sa_hit || icmp_hit || lite_hit || frag_hit) begin
        s_nxt.drop = 1'b1;
      end else begin
        s_nxt.accept = 1'b1;
      end
    end
    // host checks space first; the clamps only guard against misuse
    if (free_sum < free_dec) begin
      s_nxt.free = 13'h0000;
    end else if (free_sum - free_dec > {2'b00, qmu_pkg::TXFREE_RESET}) begin
      s_nxt.free = qmu_pkg::TXFREE_RESET;
    end else begin
      s_nxt.free = 13'(free_sum - free_dec);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '{ctrl: qmu_pkg::RXCTL2_RESET, free: qmu_pkg::TXFREE_RESET,
               rdata: 16'h0000, drop: 1'b0, accept: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  qmu_pause_timer i_qmu_pause_timer (
    .clk        (clk),
    .resetn     (resetn),
    .enable     (pause_en),
    .over_low   (receive_queue_over_low),
    .over_pause (receive_queue_over_pause),
    .pause_send (pause_frame_req),
    .running    ()
  );

  assign reg_rdata            = s_r.rdata;
  assign rx_drop              = s_r.drop;
  assign rx_accept            = s_r.accept;
  assign tx_udp_lite_csum_gen = lite_en;

  // register port checks
  a_free_reset: assert property (@(posedge clk)
    !resetn |=> (s_r.free == qmu_pkg::TXFREE_RESET))
    else $error("free space not at its reset value after reset");
  a_free_read: assert property (@(posedge clk) disable iff (!resetn)
    (reg_cs && !reg_we && reg_addr == qmu_pkg::TXFREE_ADDR) |=> (reg_rdata == {3'h0, $past(s_r.free)}))
    else $error("free space read wrong");
  a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
    !(reg_cs && !reg_we) |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_pause_write: assert property (@(posedge clk) disable iff (!resetn)
    (reg_cs && reg_we && reg_addr == qmu_pkg::RXCTL2_ADDR && reg_be[1])
      |=> (pause_en == $past(reg_wdata[qmu_pkg::PAUSE_EN_BIT])))
    else $error("pause timer enable not written");
  a_frag_write: assert property (@(posedge clk) disable iff (!resetn)
    (reg_cs && reg_we && reg_addr == qmu_pkg::RXCTL2_ADDR && reg_be[0])
      |=> (frag_pass == $past(reg_wdata[qmu_pkg::FRAG_PASS_BIT])))
    else $error("fragment pass bit not written");
  a_lite_write: assert property (@(posedge clk) disable iff (!resetn)
    (reg_cs && reg_we && reg_addr == qmu_pkg::RXCTL2_ADDR && reg_be[0])
      |=> (tx_udp_lite_csum_gen == $past(reg_wdata[qmu_pkg::LITE_EN_BIT])))
    else $error("udp lite generate enable not written");

  // transmit free space checks
  a_free_bound: assert property (@(posedge clk) disable iff (!resetn)
    s_r.free <= qmu_pkg::TXFREE_RESET)
    else $error("free space above the queue size");
  a_free_ro: assert property (@(posedge clk) disable iff (!resetn)
    (reg_cs && reg_we && reg_addr == qmu_pkg::TXFREE_ADDR && !transmit_queue_write && !transmit_queue_release)
      |=> $stable(s_r.free))
    else $error("free space changed by a register write");
  a_free_track: assert property (@(posedge clk) disable iff (!resetn)
    (transmit_queue_write && !transmit_queue_release && transmit_queue_write_bytes <= s_r.free)
      |=> (s_r.free == $past(s_r.free) - $past(transmit_queue_write_bytes)))
    else $error("free space did not drop by written bytes");
  a_free_release: assert property (@(posedge clk) disable iff (!resetn)
    (transmit_queue_release && !transmit_queue_write && free_sum <= {2'b00, qmu_pkg::TXFREE_RESET})
      |=> (s_r.free == $past(free_sum[12:0])))
    else $error("free space did not rise by released bytes");
  a_free_floor: assert property (@(posedge clk) disable iff (!resetn)
    (transmit_queue_write && !transmit_queue_release && transmit_queue_write_bytes > s_r.free)
      |=> (s_r.free == 13'h0000))
    else $error("free space did not clamp at zero");

  // receive verdict checks
  a_one_verdict: assert property (@(posedge clk) disable iff (!resetn)
    rx_frame_done |=> (rx_drop != rx_accept))
    else $error("frame without exactly one verdict");
  a_no_verdict: assert property (@(posedge clk) disable iff (!resetn)
    !rx_frame_done |=> (!rx_drop && !rx_accept))
    else $error("verdict without a frame");
  a_sa_keep: assert property (@(posedge clk) disable iff (!resetn)
    (rx_frame_done && !sa_en && !icmp_hit && !lite_hit && !frag_hit) |=> rx_accept)
    else $error("frame dropped with source filter off");
  a_icmp_frag: assert property (@(posedge clk) disable iff (!resetn)
    (rx_frame_done && rx_ip_fragment && !sa_hit && !lite_hit && !frag_hit) |=> rx_accept)
    else $error("fragmented icmp frame dropped");
  a_lite_check: assert property (@(posedge clk) disable iff (!resetn)
    (rx_frame_done && lite_en && rx_udp_lite && rx_udp_lite_csum_bad) |=> rx_drop)
    else $error("bad udp lite frame not dropped");
  a_sa_drop: assert property (@(posedge clk) disable iff (!resetn)
    (rx_frame_done && sa_en && rx_src_addr == station_addr) |=> (rx_drop && !rx_accept))
    else $error("own source address frame not dropped");
  a_icmp_drop: assert property (@(posedge clk) disable iff (!resetn)
    (rx_frame_done && icmp_en && rx_icmp && !rx_ip_fragment && rx_icmp_csum_bad) |=> rx_drop)
    else $error("bad icmp frame not dropped");
  a_icmp_keep: assert property (@(posedge clk) disable iff (!resetn)
    (rx_frame_done && !icmp_en && !sa_hit && !lite_hit && !frag_hit) |=> rx_accept)
    else $error("icmp frame dropped with check off");
  a_lite_bypass: assert property (@(posedge clk) disable iff (!resetn)
    (rx_frame_done && rx_udp_lite && !lite_en && !sa_hit && !icmp_hit && !frag_hit) |=> rx_accept)
    else $error("udp lite frame checked while disabled");
  a_frag_pass: assert property (@(posedge clk) disable iff (!resetn)
    (rx_frame_done && frag_pass && rx_ipv6_udp_frag && !sa_hit && !icmp_hit && !lite_hit) |=> rx_accept)
    else $error("fragmented ipv6 udp frame not passed");
endmodule
`default_nettype wire

/* File: verif/qmu_rx_control_tx_mem_info_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module qmu_rx_control_tx_mem_info_bench;
  logic        clk, resetn, reg_cs, reg_we, pause_frame_req, rd_now, dn_now;
  logic        receive_queue_over_low, receive_queue_over_pause;
  logic        rx_frame_done, rx_ipv6_udp_frag, rx_udp_csum_bad, rx_udp_lite, rx_udp_lite_csum_bad;
  logic        rx_icmp, rx_ip_fragment, rx_icmp_csum_bad, rx_drop, rx_accept, tx_udp_lite_csum_gen;
  logic        transmit_queue_write, transmit_queue_release;
  logic [1:0]  reg_be;
  logic [10:0] reg_addr;
  logic [12:0] transmit_queue_write_bytes, transmit_queue_release_bytes, free_m;
  logic [15:0] reg_wdata, reg_rdata, ctrl_m;
  logic [47:0] rx_src_addr, station_addr;
  logic [15:0] rdq[$];
  logic [15:0] verdict_q[$];
  int          n_errors, tests_run, n, k;

  qmu_rx_control_tx_mem_info i_qmu_rx_control_tx_mem_info (
    .clk(clk), .resetn(resetn), .reg_cs(reg_cs), .reg_we(reg_we), .reg_addr(reg_addr), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .receive_queue_over_low(receive_queue_over_low),
    .receive_queue_over_pause(receive_queue_over_pause), .pause_frame_req(pause_frame_req),
    .rx_frame_done(rx_frame_done), .rx_ipv6_udp_frag(rx_ipv6_udp_frag), .rx_udp_csum_bad(rx_udp_csum_bad),
    .rx_udp_lite(rx_udp_lite), .rx_udp_lite_csum_bad(rx_udp_lite_csum_bad), .rx_icmp(rx_icmp),
    .rx_ip_fragment(rx_ip_fragment), .rx_icmp_csum_bad(rx_icmp_csum_bad), .rx_src_addr(rx_src_addr),
    .station_addr(station_addr), .rx_drop(rx_drop), .rx_accept(rx_accept),
    .tx_udp_lite_csum_gen(tx_udp_lite_csum_gen), .transmit_queue_write(transmit_queue_write),
    .transmit_queue_write_bytes(transmit_queue_write_bytes), .transmit_queue_release(transmit_queue_release),
    .transmit_queue_release_bytes(transmit_queue_release_bytes)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // register access; expected read value noted when the request goes out
  task automatic reg_acc(input logic we, input logic [10:0] a, input logic [1:0] be, input logic [15:0] d);
    logic [15:0] m;
    @(negedge clk);
    {transmit_queue_write, transmit_queue_release} = 2'b00;
    {reg_cs, reg_we, reg_addr, reg_be, reg_wdata} = {1'b1, we, a, be, d};
    m = 16'h011f & {{8{be[1]}}, {8{be[0]}}};
    if (!we) begin
      rdq.push_back(a == 11'h176 ? ctrl_m : a == 11'h178 ? {3'h0, free_m} : 16'h0000);
    end else if (a == 11'h176) begin
      ctrl_m = (ctrl_m & ~m) | (d & m);
    end
  endtask

  task automatic idle();
    @(negedge clk);
    {reg_cs, rx_frame_done, transmit_queue_write, transmit_queue_release} = 4'h0;
  endtask

  task automatic tx_step(input logic [12:0] wb, input logic [12:0] rb);
    int t;
    @(negedge clk);
    {transmit_queue_write, transmit_queue_write_bytes} = {wb != 13'h0, wb};
    {transmit_queue_release, transmit_queue_release_bytes} = {rb != 13'h0, rb};
    t = int'(free_m) + int'(rb) - int'(wb);
    free_m = (t < 0) ? 13'h0000 : (t > 32'h1800) ? 13'h1800 : 13'(t);
    reg_acc(1'b0, 11'h178, 2'b11, 16'h0000);
  endtask

  task automatic rx_frame();
    logic [31:0] r;
    logic        d;
    @(negedge clk);
    r = $urandom;
    {rx_ipv6_udp_frag, rx_udp_csum_bad, rx_udp_lite, rx_udp_lite_csum_bad} = r[6:3];
    {rx_icmp, rx_ip_fragment, rx_icmp_csum_bad} = r[2:0];
    rx_src_addr = r[7] ? station_addr : station_addr ^ {r, 16'h0001};
    rx_frame_done = 1'b1;
    d = (ctrl_m[0] & r[7]) | (ctrl_m[1] & r[2] & ~r[1] & r[0]);
    d = d | (ctrl_m[2] & r[4] & r[3]) | (~ctrl_m[4] & r[6] & r[5]);
    verdict_q.push_back({14'h0000, d, ~d});
  endtask

  // watches the outputs one step after each edge that took a request
  initial begin
    forever begin
      @(posedge clk);
      rd_now = reg_cs & ~reg_we & resetn;
      dn_now = rx_frame_done & resetn;
      #1;
      if (rd_now && rdq.size() > 0) begin
        chk(reg_rdata, rdq.pop_front());
      end
      if (dn_now && verdict_q.size() > 0) begin
        chk({14'h0000, rx_drop, rx_accept}, verdict_q.pop_front());
      end
    end
  end

  initial begin
    {resetn, reg_cs, reg_we, reg_addr, reg_be, reg_wdata, receive_queue_over_low, receive_queue_over_pause} = '0;
    {rx_frame_done, rx_ipv6_udp_frag, rx_udp_csum_bad, rx_udp_lite, rx_udp_lite_csum_bad} = '0;
    {rx_icmp, rx_ip_fragment, rx_icmp_csum_bad, rx_src_addr} = '0;
    {transmit_queue_write, transmit_queue_write_bytes} = '0;
    {transmit_queue_release, transmit_queue_release_bytes} = '0;
    {n_errors, tests_run} = '0;
    ctrl_m = 16'hff14;
    free_m = 13'h1800;
    void'($urandom(32'h73e1));
    station_addr = 48'({$urandom, $urandom});
    repeat (2) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    reg_acc(1'b0, 11'h176, 2'b11, 16'h0000);
    reg_acc(1'b0, 11'h178, 2'b11, 16'h0000);
    reg_acc(1'b0, 11'h17a, 2'b11, 16'h0000);
    reg_acc(1'b1, 11'h176, 2'b11, 16'hffff);
    reg_acc(1'b0, 11'h176, 2'b11, 16'h0000);
    reg_acc(1'b1, 11'h176, 2'b01, 16'h0000);
    reg_acc(1'b0, 11'h176, 2'b11, 16'h0000);
    reg_acc(1'b1, 11'h176, 2'b10, 16'h0000);
    reg_acc(1'b1, 11'h178, 2'b11, 16'h0000);
    reg_acc(1'b1, 11'h17a, 2'b11, 16'hffff);
    reg_acc(1'b0, 11'h176, 2'b11, 16'h0000);
    reg_acc(1'b0, 11'h178, 2'b11, 16'h0000);
    reg_acc(1'b0, 11'h17c, 2'b11, 16'h0000);
    idle();
    chk({15'h0000, tx_udp_lite_csum_gen}, {15'h0000, ctrl_m[2]});
    for (k = 0; k < 8; k++) begin
      reg_acc(1'b1, 11'h176, 2'b11, 16'($urandom) | 16'h0010);
      idle();
      chk({15'h0000, tx_udp_lite_csum_gen}, {15'h0000, ctrl_m[2]});
      repeat (25) rx_frame();
      idle();
    end
    tx_step(13'h0004, 13'h0000);
    repeat (20) tx_step(13'($urandom_range(0, 300)), 13'($urandom_range(0, 500)));
    tx_step(13'h1fff, 13'h0000);
    tx_step(13'h0000, 13'h1fff);
    idle();
    reg_acc(1'b1, 11'h176, 2'b10, 16'h0100);
    idle();
    {receive_queue_over_low, receive_queue_over_pause} = 2'b11;
    @(negedge clk);
    receive_queue_over_pause = 1'b0;
    chk({15'h0000, pause_frame_req}, 16'h0001);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!pause_frame_req && n < 4100);
    chk(16'(n), {4'h0, qmu_pkg::PAUSE_CYCLES});
    if (n >= 4100) final_report();
    receive_queue_over_low = 1'b0;
    n = 0;
    repeat (4100) begin
      @(negedge clk);
      n += int'(pause_frame_req);
    end
    chk(16'(n), 16'h0000);
    reg_acc(1'b1, 11'h176, 2'b10, 16'h0000);
    idle();
    {receive_queue_over_low, receive_queue_over_pause} = 2'b11;
    n = 0;
    repeat (10) begin
      @(negedge clk);
      n += int'(pause_frame_req);
    end
    chk(16'(n), 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
